// ===== rtl/etc_top.sv
// External trigger terminals, comparison outputs and digital I/O with Avalon-MM registers
`include "etc_consts.svh"
module etc_top import etc_pkg::*; (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  output logic IRQ,
  input wire logic START_TERM_I_N,
  output logic START_TERM_O_N,
  output logic START_TERM_OE,
  input wire logic TRIG_TERM_I_N,
  output logic TRIG_TERM_O_N,
  output logic TRIG_TERM_OE,
  input wire logic SYNC_START_IN_N,
  input wire logic SYNC_TRIGGER_IN_N,
  output logic SYNC_START_OUT_N,
  output logic SYNC_TRIGGER_OUT_N,
  output logic START_EVENT,
  output logic TRIG_EVENT,
  input wire logic INTERLOCK_N,
  output logic INTERLOCK_ACTIVE,
  output logic [ETC_NCH-1:0] COMPARE_DONE_N,
  output logic [ETC_NCH-1:0] COMPARE_BELOW_N,
  output logic [ETC_NCH-1:0] COMPARE_WITHIN_N,
  output logic [ETC_NCH-1:0] COMPARE_ABOVE_N,
  output logic [ETC_DIO_W-1:0] DIGITAL_OUT_BIT_N,
  input wire logic [ETC_DIO_W-1:0] DIGITAL_IN_BIT_N
);
  logic wait_q;
  logic [31:0] rdata_q;
  logic [1:0] ctrl_q;
  logic [ETC_STAT_W-1:0] status_q;
  logic [ETC_STAT_W-1:0] status_d;
  logic [ETC_STAT_W-1:0] mask_q;
  logic irq_q;
  logic [ETC_DIO_W-1:0] dout_n_q;
  logic [ETC_DIO_W-1:0] din_meta_q;
  logic [ETC_DIO_W-1:0] din_q;
  logic start_ev_q;
  logic trig_ev_q;
  logic intlk_q;
  logic [1:0] pulse_n_q;
  etc_cnt_t pulse_cnt_q [2];
  logic [ETC_NCH-1:0] done_n_q;
  logic [ETC_NCH-1:0] below_n_q;
  logic [ETC_NCH-1:0] within_n_q;
  logic [ETC_NCH-1:0] above_n_q;
  etc_word_t min_q [ETC_NCH];
  etc_word_t max_q [ETC_NCH];
  etc_word_t result_q [ETC_NCH];

  // Bus handshake: one wait cycle, then the access completes
  wire logic req = AVS_READ || AVS_WRITE;
  wire logic wr_en = AVS_WRITE && !wait_q;
  wire logic rd_cap = AVS_READ && wait_q;
  wire logic sel_ctrl = AVS_ADDRESS == `ETC_OFS_CTRL;
  wire logic sel_cmd = AVS_ADDRESS == `ETC_OFS_CMD;
  wire logic sel_stat = AVS_ADDRESS == `ETC_OFS_STATUS;
  wire logic sel_mask = AVS_ADDRESS == `ETC_OFS_MASK;
  wire logic sel_dout = AVS_ADDRESS == `ETC_OFS_DOUT;
  wire logic sel_din = AVS_ADDRESS == `ETC_OFS_DIN;
  wire logic sel_lvl = AVS_ADDRESS == `ETC_OFS_LEVELS;
  wire logic [31:0] cmd_wr = (wr_en && sel_cmd) ? AVS_WRITEDATA : 32'h0000_0000;

  // Terminal and connector inputs, all active low
  wire logic st_term_fall;
  wire logic tr_term_fall;
  wire logic st_sync_fall;
  wire logic tr_sync_fall;
  wire logic intlk_lvl;
  wire logic intlk_fall;

  etc_in_filter u_st_term (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .pin_n(START_TERM_I_N),
    .asserted(),
    .fall(st_term_fall)
  );
  etc_in_filter u_tr_term (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .pin_n(TRIG_TERM_I_N),
    .asserted(),
    .fall(tr_term_fall)
  );
  etc_in_filter u_st_sync (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .pin_n(SYNC_START_IN_N),
    .asserted(),
    .fall(st_sync_fall)
  );
  etc_in_filter u_tr_sync (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .pin_n(SYNC_TRIGGER_IN_N),
    .asserted(),
    .fall(tr_sync_fall)
  );
  etc_in_filter u_intlk (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .pin_n(INTERLOCK_N),
    .asserted(intlk_lvl),
    .fall(intlk_fall)
  );

  wire etc_dir_e start_dir = etc_dir_e'(ctrl_q[`ETC_CTRL_START_DIR]);
  wire etc_dir_e trig_dir = etc_dir_e'(ctrl_q[`ETC_CTRL_TRIG_DIR]);
  // An output-mode terminal sees its own pulse; that must not re-enter as a key press
  wire logic st_term_ev = st_term_fall && (start_dir == ETC_DIR_INPUT);
  wire logic tr_term_ev = tr_term_fall && (trig_dir == ETC_DIR_INPUT);
  wire logic own_start = cmd_wr[`ETC_CMD_START];
  wire logic own_trig = cmd_wr[`ETC_CMD_TRIG];
  wire logic start_any = st_term_ev || st_sync_fall || own_start;
  wire logic trig_any = tr_term_ev || tr_sync_fall || own_trig;

  wire logic [ETC_NCH-1:0] meas_start;
  wire logic [ETC_NCH-1:0] meas_end;
  wire logic [ETC_NCH-1:0] ch_hit;
  wire etc_word_t ch_rd [ETC_NCH];
  wire logic [ETC_STAT_W-1:0] stat_set = {meas_end, intlk_fall, trig_any, start_any};
  wire logic [ETC_STAT_W-1:0] stat_clr = (wr_en && sel_stat) ? AVS_WRITEDATA[ETC_STAT_W-1:0] : '0;

  // A new event wins over a write-one-to-clear in the same cycle
  assign status_d = (status_q & ~stat_clr) | stat_set;

  // Read selection; unmapped addresses read as zero
  wire logic [31:0] ch_word = ch_hit[0] ? ch_rd[0] : (ch_hit[1] ? ch_rd[1] : 32'h0000_0000);
  wire logic [31:0] rd_word =
    sel_ctrl ? {30'h0000_0000, ctrl_q} :
    sel_stat ? {27'h000_0000, status_q} :
    sel_mask ? {27'h000_0000, mask_q} :
    sel_dout ? {16'h0000, ~dout_n_q} :
    sel_din ? {16'h0000, din_q} :
    sel_lvl ? {29'h0000_0000, ~pulse_n_q, intlk_q} :
    ch_word;

  assign AVS_WAITREQUEST = wait_q;
  assign AVS_READDATA = rdata_q;
  assign IRQ = irq_q;
  assign START_TERM_OE = ctrl_q[`ETC_CTRL_START_DIR];
  assign TRIG_TERM_OE = ctrl_q[`ETC_CTRL_TRIG_DIR];
  assign START_TERM_O_N = pulse_n_q[0];
  assign SYNC_START_OUT_N = pulse_n_q[0];
  assign TRIG_TERM_O_N = pulse_n_q[1];
  assign SYNC_TRIGGER_OUT_N = pulse_n_q[1];
  assign START_EVENT = start_ev_q;
  assign TRIG_EVENT = trig_ev_q;
  assign INTERLOCK_ACTIVE = intlk_q;
  assign COMPARE_DONE_N = done_n_q;
  assign COMPARE_BELOW_N = below_n_q;
  assign COMPARE_WITHIN_N = within_n_q;
  assign COMPARE_ABOVE_N = above_n_q;
  assign DIGITAL_OUT_BIT_N = dout_n_q;

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      wait_q <= wait_q ? !req : 1'b1;
      if (rd_cap) begin
        rdata_q <= rd_word;
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      ctrl_q <= `ETC_CTRL_RST;
      mask_q <= `ETC_MASK_RST;
      dout_n_q <= `ETC_DOUT_N_RST;
      status_q <= '0;
      irq_q <= 1'b0;
    end else begin
      if (wr_en && sel_ctrl) begin
        ctrl_q <= AVS_WRITEDATA[1:0];
      end
      if (wr_en && sel_mask) begin
        mask_q <= AVS_WRITEDATA[ETC_STAT_W-1:0];
      end
      if (wr_en && sel_dout) begin
        dout_n_q <= ~AVS_WRITEDATA[ETC_DIO_W-1:0];
      end
      status_q <= status_d;
      irq_q <= |(status_q & mask_q);
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      start_ev_q <= 1'b0;
      trig_ev_q <= 1'b0;
      intlk_q <= 1'b0;
    end else begin
      start_ev_q <= start_any;
      trig_ev_q <= trig_any;
      intlk_q <= intlk_lvl;
    end
  end

  // Own start and trigger pulses; a request during a running pulse is dropped
  // so that every falling edge stays a full width apart
  genvar gp;
  generate
    for (gp = 0; gp < 2; gp++) begin : g_pulse
      wire logic go = (gp == 0) ? own_start : own_trig;
      wire logic busy = pulse_cnt_q[gp] != '0;
      wire etc_cnt_t cnt_d = (go && !busy) ? etc_cnt_t'(`ETC_OUT_CYC) :
        (busy ? pulse_cnt_q[gp] - etc_cnt_t'(1) : '0);
      always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
          pulse_cnt_q[gp] <= '0;
          pulse_n_q[gp] <= 1'b1;
        end else begin
          pulse_cnt_q[gp] <= cnt_d;
          pulse_n_q[gp] <= cnt_d == '0;
        end
      end
    end
  endgenerate

  // Digital inputs: two-stage synchroniser, low pin reads as 1
  genvar gd;
  generate
    for (gd = 0; gd < ETC_DIO_W; gd++) begin : g_din
      logic din_sync_q;
      always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
          din_meta_q[gd] <= 1'b1;
          din_sync_q <= 1'b1;
          din_q[gd] <= 1'b0;
        end else begin
          din_meta_q[gd] <= DIGITAL_IN_BIT_N[gd];
          din_sync_q <= din_meta_q[gd];
          din_q[gd] <= !din_sync_q;
        end
      end
    end
  endgenerate

  // Per-channel limits, result and comparison outputs
  genvar gc;
  generate
    for (gc = 0; gc < ETC_NCH; gc++) begin : g_ch
      wire logic [7:0] base = 8'(`ETC_OFS_CH_BASE + gc * `ETC_OFS_CH_STRIDE);
      wire logic in_ch = (AVS_ADDRESS & ~8'h0F) == base;
      wire logic [7:0] sub = AVS_ADDRESS & 8'h0F;
      wire logic sel_min = in_ch && (sub == `ETC_OFS_CH_MIN);
      wire logic sel_max = in_ch && (sub == `ETC_OFS_CH_MAX);
      wire logic sel_res = in_ch && (sub == `ETC_OFS_CH_RESULT);
      wire logic sel_vd = in_ch && (sub == `ETC_OFS_CH_VERDICT);
      // Limits and results are two's complement; measured values may be negative
      wire logic lt_min = $signed(AVS_WRITEDATA) < $signed(min_q[gc]);
      wire logic gt_max = $signed(AVS_WRITEDATA) > $signed(max_q[gc]);
      wire logic [3:0] verdict = {~done_n_q[gc], ~above_n_q[gc], ~within_n_q[gc], ~below_n_q[gc]};
      assign meas_end[gc] = wr_en && sel_res;
      assign meas_start[gc] = cmd_wr[`ETC_CMD_MEAS0 + gc];
      assign ch_hit[gc] = sel_min || sel_max || sel_res || sel_vd;
      assign ch_rd[gc] = sel_min ? min_q[gc] : (sel_max ? max_q[gc] :
        (sel_res ? result_q[gc] : {28'h000_0000, verdict}));
      always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
          min_q[gc] <= `ETC_LIMIT_RST;
          max_q[gc] <= `ETC_LIMIT_RST;
          result_q[gc] <= `ETC_LIMIT_RST;
          done_n_q[gc] <= 1'b1;
          below_n_q[gc] <= 1'b1;
          within_n_q[gc] <= 1'b1;
          above_n_q[gc] <= 1'b1;
        end else begin
          if (wr_en && sel_min) begin
            min_q[gc] <= AVS_WRITEDATA;
          end
          if (wr_en && sel_max) begin
            max_q[gc] <= AVS_WRITEDATA;
          end
          if (meas_end[gc]) begin
            result_q[gc] <= AVS_WRITEDATA;
            done_n_q[gc] <= 1'b0;
            below_n_q[gc] <= !lt_min;
            within_n_q[gc] <= lt_min || gt_max;
            above_n_q[gc] <= !gt_max;
          end else if (meas_start[gc]) begin
            done_n_q[gc] <= 1'b1;
          end
        end
      end
    end
  endgenerate
endmodule

// ===== rtl/etc_consts.svh
// Constants of the external trigger and comparison I/O block
// Operation
// - Start and trigger terminals each set to input or output independently.
// - Start terminal input: falling edge acts as a sweep start key press.
// - Trigger terminal input: falling edge acts as a trigger key press.
// - Start terminal input carries the same signal as sync_start_in.
// - Trigger terminal input carries the same signal as sync_trigger_in.
// - Start terminal output drives own sweep start, same as sync_start_out.
// - Trigger terminal output drives own trigger, same as sync_trigger_out.
// - Output events are active-low pulses of about 10 us, falling edge marks event.
// - Per channel, compare_done goes low at measurement end, high at next start.
// - Per channel, compare_below asserted low when result is under minimum.
// - Per channel, compare_within asserted low when min <= result <= max.
// - Per channel, compare_above asserted low when result is over maximum.
// - Comparison complete and result outputs use negative logic.
// - Interlock input is active low; low means asserted.
// - Digital output driven low when its bit holds 1, else high.
// - Digital input bit reads 1 while its pin is low.
`ifndef ETC_CONSTS_SVH
`define ETC_CONSTS_SVH

`define ETC_CLK_PERIOD_NS 10
`define ETC_MIN_PULSE_NS 10000
`define ETC_IN_CYC ((`ETC_MIN_PULSE_NS + `ETC_CLK_PERIOD_NS - 1) / `ETC_CLK_PERIOD_NS)
`define ETC_OUT_CYC (`ETC_MIN_PULSE_NS / `ETC_CLK_PERIOD_NS)

`define ETC_OFS_CTRL 8'h00
`define ETC_OFS_CMD 8'h04
`define ETC_OFS_STATUS 8'h08
`define ETC_OFS_MASK 8'h0C
`define ETC_OFS_DOUT 8'h10
`define ETC_OFS_DIN 8'h14
`define ETC_OFS_LEVELS 8'h18
`define ETC_OFS_CH_BASE 8'h20
`define ETC_OFS_CH_STRIDE 8'h10
`define ETC_OFS_CH_MIN 8'h00
`define ETC_OFS_CH_MAX 8'h04
`define ETC_OFS_CH_RESULT 8'h08
`define ETC_OFS_CH_VERDICT 8'h0C

`define ETC_CTRL_START_DIR 0
`define ETC_CTRL_TRIG_DIR 1
`define ETC_CMD_START 0
`define ETC_CMD_TRIG 1
`define ETC_CMD_MEAS0 2
`define ETC_ST_START 0
`define ETC_ST_TRIG 1
`define ETC_ST_INTLK 2
`define ETC_ST_DONE0 3
`define ETC_VD_BELOW 0
`define ETC_VD_WITHIN 1
`define ETC_VD_ABOVE 2
`define ETC_VD_DONE 3

`define ETC_CTRL_RST 2'h0
`define ETC_MASK_RST 5'h00
`define ETC_DOUT_N_RST 16'hFFFF
`define ETC_LIMIT_RST 32'h0000_0000

`endif

// ===== rtl/etc_pkg.sv
// Types shared by the external trigger and comparison I/O block
package etc_pkg;
  localparam int ETC_CNT_W = 10;
  localparam int ETC_NCH = 2;
  localparam int ETC_DIO_W = 16;
  localparam int ETC_STAT_W = 5;
  typedef logic [ETC_CNT_W-1:0] etc_cnt_t;
  typedef logic [31:0] etc_word_t;
  typedef enum logic {ETC_DIR_INPUT, ETC_DIR_OUTPUT} etc_dir_e;
endpackage

// ===== rtl/etc_in_filter.sv
// Synchroniser and minimum-width falling-edge filter for one active-low input
`include "etc_consts.svh"
module etc_in_filter import etc_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic pin_n,
  output logic asserted,
  output logic fall
);
  logic meta_q;
  logic sync_q;
  etc_cnt_t cnt_q;
  etc_cnt_t cnt_d;
  logic asserted_q;
  logic fall_q;
  wire logic hit = !sync_q && (cnt_q == etc_cnt_t'(`ETC_IN_CYC - 1));

  // Count saturates so a long low level yields exactly one event
  assign cnt_d = sync_q ? '0 : (hit ? cnt_q : cnt_q + etc_cnt_t'(1));
  assign asserted = asserted_q;
  assign fall = fall_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      cnt_q <= '0;
      asserted_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      meta_q <= pin_n;
      sync_q <= meta_q;
      cnt_q <= cnt_d;
      asserted_q <= !sync_q && (hit || asserted_q);
      fall_q <= hit && !asserted_q;
    end
  end
endmodule

// ===== testbench/etc_top_properties.sv
// Concurrent checks on the pins of the external trigger and compare block
`include "etc_consts.svh"
module etc_top_properties import etc_pkg::*; (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic AVS_WAITREQUEST,
  input wire logic START_TERM_O_N,
  input wire logic TRIG_TERM_O_N,
  input wire logic SYNC_START_OUT_N,
  input wire logic SYNC_TRIGGER_OUT_N,
  input wire logic START_EVENT,
  input wire logic INTERLOCK_N,
  input wire logic INTERLOCK_ACTIVE,
  input wire logic [ETC_NCH-1:0] COMPARE_DONE_N,
  input wire logic [ETC_NCH-1:0] COMPARE_BELOW_N,
  input wire logic [ETC_NCH-1:0] COMPARE_WITHIN_N,
  input wire logic [ETC_NCH-1:0] COMPARE_ABOVE_N
);
  localparam int OUT_CYC = `ETC_OUT_CYC;
  localparam int IN_CYC = `ETC_IN_CYC;
  logic [11:0] s_low_q, t_low_q, i_low_q;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  // Runs of low cycles; they saturate so a stuck pin cannot wrap back to a legal count
  always_ff @(posedge CORE_CLK) begin
    s_low_q <= (SYS_RST || START_TERM_O_N) ? 12'h000 : s_low_q + 12'(s_low_q != 12'hFFF);
    t_low_q <= (SYS_RST || TRIG_TERM_O_N) ? 12'h000 : t_low_q + 12'(t_low_q != 12'hFFF);
    i_low_q <= (SYS_RST || INTERLOCK_N) ? 12'h000 : i_low_q + 12'(i_low_q != 12'hFFF);
  end
  AST_WAIT_ONE: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("waitrequest not low one cycle after request");
  AST_WAIT_SHORT: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low for more than one cycle");
  AST_START_MIRROR: assert property (START_TERM_O_N == SYNC_START_OUT_N)
    else $error("start terminal and sync start output differ");
  AST_TRIG_MIRROR: assert property (TRIG_TERM_O_N == SYNC_TRIGGER_OUT_N)
    else $error("trigger terminal and sync trigger output differ");
  AST_START_WIDTH: assert property (!$past(SYS_RST) && $rose(START_TERM_O_N) |-> s_low_q == OUT_CYC)
    else $error("start output pulse width wrong");
  AST_TRIG_WIDTH: assert property (!$past(SYS_RST) && $rose(TRIG_TERM_O_N) |-> t_low_q == OUT_CYC)
    else $error("trigger output pulse width wrong");
  AST_EVENT_ONE: assert property (START_EVENT |=> !START_EVENT)
    else $error("start event longer than one cycle");
  AST_INTLK_FILT: assert property ($rose(INTERLOCK_ACTIVE) |-> i_low_q >= IN_CYC)
    else $error("interlock accepted before minimum low time");
  AST_VERDICT_EXCL: assert property ((~COMPARE_WITHIN_N & (~COMPARE_BELOW_N | ~COMPARE_ABOVE_N)) == '0)
    else $error("within asserted together with below or above");
  AST_VERDICT_ON_DONE: assert property (!$past(SYS_RST) |-> (COMPARE_DONE_N &
    ((COMPARE_BELOW_N ^ $past(COMPARE_BELOW_N)) | (COMPARE_WITHIN_N ^ $past(COMPARE_WITHIN_N)) |
    (COMPARE_ABOVE_N ^ $past(COMPARE_ABOVE_N)))) == '0)
    else $error("compare result changed without measurement end");
  COV_START_PULSE: cover property ($fell(START_TERM_O_N));
  COV_INTLK: cover property ($rose(INTERLOCK_ACTIVE));
  COV_DONE: cover property ($fell(COMPARE_DONE_N[1]));
endmodule
bind etc_top etc_top_properties u_etc_top_properties (.CORE_CLK, .SYS_RST, .AVS_READ, .AVS_WRITE,
  .AVS_WAITREQUEST, .START_TERM_O_N, .TRIG_TERM_O_N, .SYNC_START_OUT_N, .SYNC_TRIGGER_OUT_N, .START_EVENT,
  .INTERLOCK_N, .INTERLOCK_ACTIVE, .COMPARE_DONE_N, .COMPARE_BELOW_N, .COMPARE_WITHIN_N, .COMPARE_ABOVE_N);

// ===== testbench/etc_handler_model.sv
// Behavioural external handler driving the input pins of the block
module etc_handler_model (
  input wire logic clk,
  output logic [4:0] line_n,
  output logic [15:0] din_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // Lines 0..4: start terminal, trigger terminal, sync start, sync trigger, interlock; idle high like TTL
  initial line_n = 5'h1F;
  initial din_n = 16'hFFFF;
  task automatic pulse(input int idx, input int cyc);
    @(posedge clk);
    line_n[idx] <= 1'b0;
    repeat (cyc) @(posedge clk);
    line_n[idx] <= 1'b1;
  endtask
  task automatic level(input int idx, input logic lvl);
    @(posedge clk);
    line_n[idx] <= lvl;
  endtask
  task automatic set_din(input logic [15:0] v);
    @(posedge clk);
    din_n <= ~v;
  endtask
endmodule

// ===== testbench/external_trigger_compare_io_test.sv
// Self-checking bench for the external trigger, compare and digital I/O block
`include "etc_consts.svh"
module external_trigger_compare_io_test import etc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [7:0] adr = 8'h00;
  etc_word_t wdat = 32'h0000_0000;
  etc_word_t rdata, rdat;
  logic wait_rq, irq, s_o, s_oe, t_o, t_oe, ss_o, st_o, s_ev, t_ev, ilk_act;
  logic [4:0] ln;
  logic [ETC_NCH-1:0] dn, bl, wi, ab;
  logic [ETC_DIO_W-1:0] dout, din;
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int ev [2] = '{0, 0};
  initial forever #5 clk = ~clk;
  etc_top u_etc_top (.CORE_CLK(clk), .SYS_RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wdat), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_rq), .IRQ(irq), .START_TERM_I_N(ln[0]),
    .START_TERM_O_N(s_o), .START_TERM_OE(s_oe), .TRIG_TERM_I_N(ln[1]), .TRIG_TERM_O_N(t_o), .TRIG_TERM_OE(t_oe),
    .SYNC_START_IN_N(ln[2]), .SYNC_TRIGGER_IN_N(ln[3]), .SYNC_START_OUT_N(ss_o), .SYNC_TRIGGER_OUT_N(st_o),
    .START_EVENT(s_ev), .TRIG_EVENT(t_ev), .INTERLOCK_N(ln[4]), .INTERLOCK_ACTIVE(ilk_act),
    .COMPARE_DONE_N(dn), .COMPARE_BELOW_N(bl), .COMPARE_WITHIN_N(wi), .COMPARE_ABOVE_N(ab),
    .DIGITAL_OUT_BIT_N(dout), .DIGITAL_IN_BIT_N(din));
  etc_handler_model u_etc_handler_model (.clk(clk), .line_n(ln), .din_n(din));
  task automatic complete_run();
    if (err_count == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Event counters and the hang limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (s_ev === 1'b1) ev[0] <= ev[0] + 1;
    if (t_ev === 1'b1) ev[1] <= ev[1] + 1;
    if (cyc == 40000) begin
      err_count++;
      complete_run();
    end
  end
  task automatic check(input etc_word_t got, input etc_word_t exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One Avalon transfer; the request stands until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, input etc_word_t d);
    @(posedge clk);
    adr <= a;
    wdat <= d;
    wr <= w;
    rd <= !w;
    do @(posedge clk); while (wait_rq !== 1'b0);
    rdat = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic t_reset();
    check(32'({t_oe, s_oe}), 32'h0000_0000);
    check(32'({s_o, t_o, ss_o, st_o}), 32'h0000_000F);
    check(32'(dout), 32'h0000_FFFF);
    check(32'({dn, bl, wi, ab}), 32'h0000_00FF);
    bus(1, 8'hFC, 32'h0000_1234);
    bus(0, 8'hFC, 32'h0000_0000);
    check(rdat, 32'h0000_0000);
  endtask
  task automatic t_dio();
    bus(1, `ETC_OFS_DOUT, 32'h0000_A5C3);
    bus(0, `ETC_OFS_DOUT, 32'h0000_0000);
    check(rdat, 32'h0000_A5C3);
    check(32'(dout), 32'h0000_5A3C);
    u_etc_handler_model.set_din(16'h8001);
    rdat = 32'h0000_0000;
    repeat (600) if (rdat !== 32'h0000_8001) bus(0, `ETC_OFS_DIN, 32'h0000_0000);
    check(rdat, 32'h0000_8001);
  endtask
  task automatic t_out();
    int n;
    int e;
    bus(1, `ETC_OFS_CTRL, 32'h0000_0003);
    bus(1, `ETC_OFS_MASK, 32'h0000_0003);
    check(32'({t_oe, s_oe}), 32'h0000_0003);
    for (int k = 0; k < 2; k++) begin
      e = ev[k];
      bus(1, `ETC_OFS_CMD, 32'(1 << k));
      tick(1);
      check(32'(k ? {t_o, st_o} : {s_o, ss_o}), 32'h0000_0000);
      n = 0;
      while ((k ? t_o : s_o) === 1'b0) begin
        tick(1);
        n++;
      end
      check(32'(n), `ETC_OUT_CYC);
      // Event counter updates on the edge after the pulse starts, so look once it has settled
      check(32'(ev[k] - e), 32'h0000_0001);
      check(32'(irq), 32'h0000_0001);
      bus(1, `ETC_OFS_STATUS, 32'h0000_0003);
      tick(2);
      check(32'(irq), 32'h0000_0000);
    end
  endtask
  task automatic t_in();
    int e0;
    bus(1, `ETC_OFS_CTRL, 32'h0000_0000);
    for (int i = 0; i < 6; i++) begin
      // Last two passes: start, then trigger terminal switched to output, so its input is ignored
      if (i >= 4) bus(1, `ETC_OFS_CTRL, 32'(i - 3));
      e0 = ev[i % 2];
      u_etc_handler_model.pulse(i % 4, 1050);
      tick(5);
      check(32'(ev[i % 2] - e0), 32'(i < 4));
    end
    bus(1, `ETC_OFS_CTRL, 32'h0000_0000);
    e0 = ev[0];
    u_etc_handler_model.pulse(0, 900);
    tick(5);
    check(32'(ev[0] - e0), 32'h0000_0000);
  endtask
  task automatic t_ilk();
    bus(1, `ETC_OFS_MASK, 32'h0000_0004);
    u_etc_handler_model.level(4, 1'b0);
    tick(1100);
    check(32'({irq, ilk_act}), 32'h0000_0003);
    bus(0, `ETC_OFS_LEVELS, 32'h0000_0000);
    check(rdat & 32'h0000_0001, 32'h0000_0001);
    bus(1, `ETC_OFS_STATUS, 32'h0000_0004);
    tick(2);
    check(32'(irq), 32'h0000_0000);
    u_etc_handler_model.level(4, 1'b1);
  endtask
  task automatic t_cmp();
    etc_word_t res [4] = '{32'hFFFF_FFFA, 32'hFFFF_FFFB, 32'h0000_0064, 32'h0000_0065};
    logic [2:0] exp [4] = '{3'h1, 3'h2, 3'h2, 3'h4};
    logic [7:0] b;
    for (int ch = 0; ch < 2; ch++) begin
      b = 8'(`ETC_OFS_CH_BASE + ch * `ETC_OFS_CH_STRIDE);
      bus(1, b, 32'hFFFF_FFFB);
      bus(1, b + 8'h04, 32'h0000_0064);
      for (int i = 0; i < 4; i++) begin
        bus(1, `ETC_OFS_CMD, 32'(4 << ch));
        tick(1);
        check(32'(dn[ch]), 32'h0000_0001);
        bus(1, b + 8'h08, res[i]);
        tick(1);
        check(32'({dn[ch], ab[ch], wi[ch], bl[ch]}), 32'({1'b0, ~exp[i]}));
        bus(0, b + 8'h0C, 32'h0000_0000);
        check(rdat, 32'({1'b1, exp[i]}));
      end
    end
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    tick(1);
    t_reset();
    t_dio();
    t_out();
    t_in();
    t_ilk();
    t_cmp();
    complete_run();
  end
endmodule
